// ### logic/ppa_defines.vh
// constants for the period and pulse accumulator channel
`ifndef PPA_DEFINES_VH
`define PPA_DEFINES_VH
`define PPA_ACC_W          24
`define PPA_CNT_W          19
`define PPA_SMP_W          23
`define PPA_STAT_W         8
`define PPA_OVF_FLAG       8'h80
`define PPA_MODE_LOW       2'h0
`define PPA_MODE_HIGH      2'h1
`define PPA_MODE_FALL      2'h2
`define PPA_MODE_RISE      2'h3
`define PPA_PRIO_OFF       2'h0
`define PPA_WCT_PERIOD     8'h50
`define PPA_WCT_PULSE      8'h64
`define PPA_WCT_OVF_EXTRA  8'h08
`endif

// ### logic/ppa_period_pulse_accumulator.v
// period and pulse accumulator measurement channel
// How it works
// - immediate outputs give running sum and periods counted, no flag needed
// - running sum also refreshed every sample interval in period modes, and in pulse modes only while a pulse is measured
// - count shows completed periods only, partial period never counted
// - running sum and count may disagree; sum granularity follows sample rate
// - pulse modes track previous pin level; a pulse ending inside its service window runs on to the next end edge
// - pulse modes see both edges, but the 100 clock start-edge service blocks end edges, so short pulses run on
// - period modes react to the active edge only
// - each edge service busy 80 clocks period, 100 clocks pulse
// - overflow adds 8 clocks to the service time
// - one of two timebases chosen by a selector
// - four modes: low total, high total, falling period, rising period
// - limit 0 to 0x7ffff; zero and one both mean one period
// - sample interval 0 to 0x7fffff; longer than span gives no update
// - disable takes effect only after the current service ends
// - channel disabled out of reset
// - at completion buffer result, raise requests, restart
// - completion flags set in the same cycle as result; cleared by software or dma read
// - overflow status 0x80 past 24 bits, copied at completion then cleared
`include "ppa_defines.vh"
module ppa_period_pulse_accumulator
(
  input  wire        clk,
  input  wire        reset_n,
  input  wire        signalIn,
  input  wire        timebaseOneTick,
  input  wire        timebaseTwoTick,
  input  wire [1:0]  channelPriority,
  input  wire        timebaseSel,
  input  wire [1:0]  measureMode,
  input  wire [18:0] maxCount,
  input  wire [22:0] sampleTime,
  input  wire        intEnable,
  input  wire        dmaEnable,
  input  wire        intClear,
  input  wire        dmaResultRead,
  output reg  [23:0] resultValue,
  output reg  [7:0]  resultStatus,
  output reg  [23:0] immediateValue,
  output reg  [7:0]  immediateStatus,
  output reg  [18:0] immediateCount,
  output reg         intFlag,
  output reg         dmaFlag,
  output wire        intRequest,
  output wire        dmaRequest,
  output wire        serviceBusy,
  output reg         channelEnabled
);
  localparam ST_IDLE    = 2'h0;
  localparam ST_ARM     = 2'h1;
  localparam ST_MEASURE = 2'h2;

  reg        pinSync1_q;
  reg        pinSync2_q;
  reg        pinPrev_q;
  reg        tb1Sync1_q;
  reg        tb1Sync2_q;
  reg        tb1Prev_q;
  reg        tb2Sync1_q;
  reg        tb2Sync2_q;
  reg        tb2Prev_q;
  reg [1:0]  state_q;
  reg [23:0] accum_q;
  reg [23:0] partial_q;
  reg [22:0] sampleCnt_q;
  reg [7:0]  running_overflow_status_q;
  reg [7:0]  busyCnt_q;
  reg        busyOvf_q;
  reg        inPulse_q;

  // adds with saturation, overflow reported separately
  function [24:0] sat_add;
    input [23:0] a;
    input [23:0] b;
    reg   [24:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s[24])
        sat_add = {1'b1, 24'hffffff};
      else
        sat_add = s;
    end
  endfunction

  // one-clock pulse on a low-to-high step
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  // base service window; overflow stretch is added by the busy counter
  function [7:0] wct_of;
    input pulse;
    begin
      if (pulse)
        wct_of = `PPA_WCT_PULSE;
      else
        wct_of = `PPA_WCT_PERIOD;
    end
  endfunction

  // both pin and timebase ticks come from outside this clock
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
      pinPrev_q  <= 1'b0;
      tb1Sync1_q <= 1'b0;
      tb1Sync2_q <= 1'b0;
      tb1Prev_q  <= 1'b0;
      tb2Sync1_q <= 1'b0;
      tb2Sync2_q <= 1'b0;
      tb2Prev_q  <= 1'b0;
    end
    else
    begin
      pinSync1_q <= signalIn;
      pinSync2_q <= pinSync1_q;
      pinPrev_q  <= pinSync2_q;
      tb1Sync1_q <= timebaseOneTick;
      tb1Sync2_q <= tb1Sync1_q;
      tb1Prev_q  <= tb1Sync2_q;
      tb2Sync1_q <= timebaseTwoTick;
      tb2Sync2_q <= tb2Sync1_q;
      tb2Prev_q  <= tb2Sync2_q;
    end
  end

  wire tbTick = timebaseSel ? rise_of(tb2Sync2_q, tb2Prev_q)
                            : rise_of(tb1Sync2_q, tb1Prev_q);
  wire riseEdge = rise_of(pinSync2_q, pinPrev_q);
  wire fallEdge = rise_of(pinPrev_q, pinSync2_q);
  wire pulseMode = (measureMode == `PPA_MODE_LOW) || (measureMode == `PPA_MODE_HIGH);
  // asserted level for pulse modes; low mode measures while the pin is low
  wire activeLvl = (measureMode == `PPA_MODE_HIGH);
  wire startEdge = activeLvl ? riseEdge : fallEdge;
  wire endEdge   = activeLvl ? fallEdge : riseEdge;
  wire periodEdge = (measureMode == `PPA_MODE_RISE) ? riseEdge : fallEdge;
  wire enReq = (channelPriority != `PPA_PRIO_OFF);
  wire [18:0] limit = (maxCount == 19'h00000) ? 19'h00001 : maxCount;

  assign serviceBusy = (busyCnt_q != 8'h00);
  assign intRequest  = intFlag & intEnable;
  assign dmaRequest  = dmaFlag & dmaEnable;

  // events that need a service: pulse ends, active edges, pulse starts
  wire pulseEnd  = pulseMode & inPulse_q & endEdge;
  wire pulseBeg  = pulseMode & startEdge;
  wire perEvent  = ~pulseMode & periodEdge;
  wire sampleHit = (sampleTime != 23'h000000) && (sampleCnt_q >= sampleTime) && tbTick;
  wire [24:0] partialInc = sat_add(partial_q, 24'h000001);

  reg [24:0] sumNow;
  reg [24:0] sumSample;
  reg        done;
  reg [18:0] nextCount;
  always @*
  begin
    sumNow    = sat_add(accum_q, partial_q);
    sumSample = sat_add(immediateValue, partial_q);
    nextCount = immediateCount + 19'h00001;
    done      = (nextCount >= limit);
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q         <= ST_IDLE;
      channelEnabled  <= 1'b0;
      accum_q         <= 24'h000000;
      partial_q       <= 24'h000000;
      sampleCnt_q     <= 23'h000000;
      running_overflow_status_q       <= 8'h00;
      busyCnt_q       <= 8'h00;
      busyOvf_q       <= 1'b0;
      inPulse_q       <= 1'b0;
      resultValue     <= 24'h000000;
      resultStatus    <= 8'h00;
      immediateValue  <= 24'h000000;
      immediateStatus <= 8'h00;
      immediateCount  <= 19'h00000;
      intFlag         <= 1'b0;
      dmaFlag         <= 1'b0;
    end
    else
    begin
      // a service in progress finishes before disable lands
      if (!serviceBusy)
        channelEnabled <= enReq;
      // overflow extends the window with no idle gap in between
      if ((busyCnt_q == 8'h01) && busyOvf_q)
      begin
        busyCnt_q <= `PPA_WCT_OVF_EXTRA;
        busyOvf_q <= 1'b0;
      end
      else if (busyCnt_q != 8'h00)
        busyCnt_q <= busyCnt_q - 8'h01;
      // set wins over clear
      if (intClear)
        intFlag <= 1'b0;
      if (dmaResultRead)
        dmaFlag <= 1'b0;
      if (tbTick)
      begin
        partial_q   <= partialInc[23:0];
        sampleCnt_q <= sampleCnt_q + 23'h000001;
      end
      case (state_q)
        ST_IDLE:
        begin
          inPulse_q <= 1'b0;
          if (channelEnabled)
          begin
            accum_q        <= 24'h000000;
            immediateValue <= 24'h000000;
            immediateCount <= 19'h00000;
            running_overflow_status_q      <= 8'h00;
            state_q        <= ST_ARM;
          end
        end
        ST_ARM:
        begin
          if (!channelEnabled)
            state_q <= ST_IDLE;
          else if (!serviceBusy && (pulseBeg || perEvent))
          begin
            partial_q   <= 24'h000000;
            sampleCnt_q <= 23'h000000;
            inPulse_q   <= pulseMode;
            busyCnt_q   <= wct_of(pulseMode);
            state_q     <= ST_MEASURE;
          end
        end
        default:
        begin
          if (!channelEnabled)
            state_q <= ST_IDLE;
          else if (!serviceBusy && (pulseEnd || perEvent))
          begin
            busyCnt_q   <= wct_of(pulseMode);
            partial_q   <= 24'h000000;
            sampleCnt_q <= 23'h000000;
            inPulse_q   <= 1'b0;
            if (sumNow[24])
              busyOvf_q <= 1'b1;
            if (done)
            begin
              resultValue     <= sumNow[23:0];
              resultStatus    <= sumNow[24] ? `PPA_OVF_FLAG : running_overflow_status_q;
              running_overflow_status_q       <= 8'h00;
              immediateStatus <= 8'h00;
              accum_q         <= 24'h000000;
              immediateValue  <= 24'h000000;
              immediateCount  <= 19'h00000;
              intFlag         <= 1'b1;
              dmaFlag         <= 1'b1;
            end
            else
            begin
              accum_q        <= sumNow[23:0];
              immediateValue <= sumNow[23:0];
              immediateCount <= nextCount;
              if (sumNow[24])
              begin
                running_overflow_status_q       <= `PPA_OVF_FLAG;
                immediateStatus <= `PPA_OVF_FLAG;
              end
            end
            // period modes start the next period on this same edge
            if (pulseMode)
              state_q <= ST_ARM;
          end
          else if (pulseMode && !inPulse_q)
            state_q <= ST_ARM;
          else if (sampleHit)
          begin
            // count stays at completed periods; sum races ahead
            immediateValue <= sumSample[23:0];
            // the tick that triggers the update opens the next slice
            partial_q      <= 24'h000001;
            accum_q        <= sumSample[23:0];
            sampleCnt_q    <= 23'h000001;
            if (sumSample[24])
            begin
              running_overflow_status_q       <= `PPA_OVF_FLAG;
              immediateStatus <= `PPA_OVF_FLAG;
            end
          end
        end
      endcase
    end
  end
endmodule

// ### verification/ppa_acc_asserts.sv
// port assertions for the accumulator channel
`include "ppa_defines.vh"
module ppa_acc_asserts
(
  input wire        clk,
  input wire        reset_n,
  input wire [1:0]  channelPriority,
  input wire [18:0] maxCount,
  input wire        intEnable,
  input wire        dmaEnable,
  input wire        intClear,
  input wire        dmaResultRead,
  input wire [7:0]  resultStatus,
  input wire [18:0] immediateCount,
  input wire        intFlag,
  input wire        dmaFlag,
  input wire        intRequest,
  input wire        dmaRequest,
  input wire        serviceBusy,
  input wire        channelEnabled
);
  reg  [7:0] busyCnt_q;
  wire [7:0] busyCnt_d = serviceBusy ? busyCnt_q + 8'h01 : 8'h00;
  always @(posedge clk)
    busyCnt_q <= reset_n ? busyCnt_d : 8'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_int_gate: assert property (intRequest == (intFlag & intEnable))
    else $error("interrupt request not gated by flag");
  a_dma_gate: assert property (dmaRequest == (dmaFlag & dmaEnable))
    else $error("dma request not gated by flag");
  a_int_sticky: assert property (intFlag && !intClear |=> intFlag)
    else $error("interrupt flag dropped without clear");
  a_dma_sticky: assert property (dmaFlag && !dmaResultRead |=> dmaFlag)
    else $error("dma flag dropped without read");
  a_count_clear: assert property ($rose(intFlag) |-> immediateCount == 19'h0)
    else $error("period count not cleared at completion");
  a_status_code: assert property (resultStatus inside {8'h00, `PPA_OVF_FLAG})
    else $error("final status holds an odd code");
  a_busy_length: assert property ($fell(serviceBusy) |-> busyCnt_q inside
    {`PPA_WCT_PERIOD, `PPA_WCT_PULSE, 8'h58, 8'h6c}) else $error("service window length");
  a_busy_hold: assert property (serviceBusy && channelEnabled |=> channelEnabled)
    else $error("disable landed inside a service");
  a_idle_off: assert property (channelPriority == `PPA_PRIO_OFF && !serviceBusy
    |=> !channelEnabled) else $error("disable not taken while idle");
  a_count_range: assert property (channelEnabled |->
    immediateCount < ((maxCount > 19'h1) ? maxCount : 19'h1)) else $error("count past limit");
  cover property ($rose(intFlag));
  cover property ($fell(serviceBusy) && busyCnt_q == `PPA_WCT_PULSE);
  cover property ($fell(serviceBusy) && busyCnt_q == `PPA_WCT_PERIOD);
endmodule
bind ppa_period_pulse_accumulator ppa_acc_asserts ppa_acc_asserts_i (.*);

// ### verification/ppa_pin_model.sv
// measured pin and free running timebases
module ppa_pin_model
#(parameter int HIGH_LEN = 200, parameter int LOW_LEN = 120)
(
  input  wire  clk,
  output logic pinLevel,
  output logic tickOne,
  output logic tickTwo
);
  timeunit 1ns;
  timeprecision 1ps;
  int         phase = 0;
  logic [2:0] tickCnt = 3'h0;
  always @(posedge clk)
  begin
    tickCnt <= tickCnt + 3'h1;
    phase <= (phase == HIGH_LEN + LOW_LEN - 1) ? 0 : phase + 1;
  end
  // edges spaced past the busy window and off the tick edges
  assign pinLevel = (phase < HIGH_LEN);
  assign tickOne = tickCnt[1];
  assign tickTwo = tickCnt[2];
endmodule

// ### verification/tb_ppa_period_pulse_accumulator.sv
// self-checking bench for the accumulator channel
module tb_ppa_period_pulse_accumulator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset_n = 1'b0, timebaseSel = 1'b0;
  logic        intEnable = 1'b1, dmaEnable = 1'b0, intClear = 1'b0, dmaResultRead = 1'b0;
  logic [1:0]  channelPriority = 2'h0, measureMode = 2'h0;
  logic [18:0] maxCount = 19'h0;
  logic [22:0] sampleTime = 23'h0;
  wire         signalIn, timebaseOneTick, timebaseTwoTick, intFlag, dmaFlag;
  wire         intRequest, dmaRequest, serviceBusy, channelEnabled;
  wire [23:0]  resultValue, immediateValue;
  wire [7:0]   resultStatus, immediateStatus;
  wire [18:0]  immediateCount;
  int          miscompares = 0, n_tests = 0, cycles = 0, tp, n, e;
  logic [23:0] v;
  always #4 clk = ~clk;
  ppa_pin_model ppa_pin_model_i (.clk(clk), .pinLevel(signalIn),
    .tickOne(timebaseOneTick), .tickTwo(timebaseTwoTick));
  ppa_period_pulse_accumulator ppa_period_pulse_accumulator_i (.*);
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task restart(input logic [1:0] m, input logic [18:0] lim, input logic [22:0] smp);
    reset_n <= 1'b0;
    channelPriority <= 2'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    measureMode <= m;
    timebaseSel <= m[0];
    dmaEnable <= m[1];
    maxCount <= lim;
    sampleTime <= smp;
    #1 check("enabled out of reset", channelEnabled, 0);
    check("result out of reset", resultValue, 0);
    @(posedge clk) channelPriority <= 2'h1;
  endtask
  task wait_until_count(input logic [18:0] c);
    for (int i = 0; i < 3000 && immediateCount !== c; i++) @(posedge clk);
  endtask
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      restart(m, (m == 0) ? 19'h0 : 19'h2, 23'h0);
      for (int i = 0; i < 4000 && intFlag !== 1'b1; i++) @(posedge clk);
      #1;
      tp = m[0] ? 8 : 4;
      n = (m == 0) ? 1 : 2;
      e = n * ((m == 0) ? 120 : (m == 1) ? 200 : 320) / tp;
      check("total in mode", resultValue >= e - 2 && resultValue <= e + 2, 1);
      check("result status", resultStatus, 0);
      check("int request", intRequest, 1);
      check("dma request", dmaRequest, m[1]);
      @(posedge clk) {intClear, dmaResultRead} <= 2'h3;
      @(posedge clk) {intClear, dmaResultRead} <= 2'h0;
      channelPriority <= 2'h0;
      #1 check("flags cleared", {intFlag, dmaFlag}, 0);
      for (int i = 0; i < 120 && channelEnabled !== 1'b0; i++) @(posedge clk);
      #1 check("disable lands", channelEnabled, 0);
      $display("mode test %0d done", m);
    end
    for (int k = 0; k < 2; k++)
    begin
      restart(2'h1, 19'h6, k ? 23'h7fffff : 23'h00000a);
      wait_until_count(19'h3);
      for (int i = 0; i < 400 && signalIn !== 1'b1; i++) @(posedge clk);
      repeat (120) @(posedge clk);
      #1 check("count in fourth pulse", immediateCount, 3);
      v = immediateValue;
      check("immediate status", immediateStatus, 0);
      if (k == 0)
        check("partial pulse added", v >= 84 && v <= 87, 1);
      else
        check("no sample update", v >= 74 && v <= 76, 1);
      $display("immediate test %0d done", k);
    end
    report_and_stop();
  end
endmodule
